// *** logic/lke_regs.svh ***
// Register offsets, bit positions and reset values of the emulation control
// Operation
// - a20_state holds gate A20 level, compared with port 60h data in sequence
// - aux_irq_active latches IRQ12 rising edge; writing 1 clears it
// - kbd_irq_active latches IRQ1 rising edge; writing 1 clears it
// - a20_sequence set by D1h write to port 64h, cleared by other values
// - ext_irq_enable lets either keyboard line raise an emulation interrupt
// - ext_irq_enable acts whether or not emulation is enabled
// - legacy_irq_enable keeps legacy line asserted while output-full is 1
// - aux-output-full selects IRQ12 when 1, IRQ1 when 0
// - char_pending raises emulation interrupt when output-full falls to 0
// - emul_irq_status is read-only, shows current emulation interrupt state
// - emul_enable switches on legacy emulation and its emulation interrupts
// - with emulation on, ports 60h/64h decode and legacy lines are enabled
// - control register sits at offset 100h of the memory space
// - port 60h read returns output byte and clears output-full
// - port 60h write captures byte, sets input-full, clears command/data
`ifndef LKE_REGS_SVH
`define LKE_REGS_SVH

`define LKE_OFS_CTRL 12'h100
`define LKE_IO_DATA 8'h60
`define LKE_IO_CMD 8'h64
`define LKE_CMD_A20 8'hD1
`define LKE_CTRL_RST 32'h0000_0000
`define LKE_BIT_A20_STATE 8
`define LKE_BIT_AUXA 7
`define LKE_BIT_KBDA 6
`define LKE_BIT_SEQ 5
`define LKE_BIT_EXT 4
`define LKE_BIT_LEG 3
`define LKE_BIT_CP 2
`define LKE_BIT_EI 1
`define LKE_BIT_EE 0
`define LKE_A20_DATA_BIT 1
`define LKE_NUM_LINES 2
`define LKE_LINE_KBD 0
`define LKE_LINE_AUX 1

`endif

// *** logic/lke_pkg.sv ***
// Types shared by the legacy keyboard emulation control logic
package lke_pkg;

  // Writable control fields
  typedef struct packed {
    logic a20_state;
    logic a20_sequence;
    logic ext_irq_enable;
    logic legacy_irq_enable;
    logic char_pending;
    logic emul_enable;
  } lke_ctrl_t;

  // Side-effect strobes toward the status and data registers
  typedef struct packed {
    logic clr_out_full;
    logic set_in_full;
    logic clr_in_full;
    logic set_cmd_data;
    logic clr_cmd_data;
    logic load_in_data;
  } lke_strb_t;

  // State of the main control module
  typedef struct packed {
    lke_ctrl_t ctrl;
    logic emul_evt;
    logic out_full_d;
    logic [31:0] mem_rdata;
    logic [7:0] io_rdata;
    logic [7:0] in_data;
    lke_strb_t strb;
  } lke_state_t;

  // State of one interrupt edge latch
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic active;
  } lke_edge_t;

endpackage : lke_pkg

// *** logic/lke_edge_latch.sv ***
// Synchronised rising-edge latch with write-one-to-clear
`timescale 1ns/1ps
module lke_edge_latch (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic irq_pin,
  input wire logic clr,
  output logic active
);

  lke_pkg::lke_edge_t st_r;
  lke_pkg::lke_edge_t st_nxt;

  // Two-stage sync, then edge detect on the second stage; a set wins over clr
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = irq_pin;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    if (clr) begin
      st_nxt.active = 1'b0;
    end
    if (st_r.sync2 && !st_r.prev) begin
      st_nxt.active = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.active;

endmodule : lke_edge_latch

// *** logic/lke_ctrl.sv ***
// Legacy keyboard/mouse emulation control register and interrupt steering
`timescale 1ns/1ps
`include "lke_regs.svh"
module lke_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  // Memory-space register port of the host controller function
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [11:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  // Legacy I/O cycle port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_hit,
  output logic [7:0] io_rdata,
  output logic [7:0] in_data,
  // Flags and data from the status and output registers
  input wire logic out_full,
  input wire logic aux_out_full,
  input wire logic [7:0] out_data,
  input wire logic [7:0] status_data,
  // Side-effect strobes toward the status register
  output lke_pkg::lke_strb_t status_strb,
  // Keyboard controller interrupt pins
  input wire logic kbd_irq_pin,
  input wire logic aux_irq_pin,
  // Interrupt outputs
  output logic irq1_out,
  output logic irq12_out,
  output logic emul_irq
);

  lke_pkg::lke_state_t st_r;
  lke_pkg::lke_state_t st_nxt;
  logic [`LKE_NUM_LINES-1:0] irq_pins;
  logic [`LKE_NUM_LINES-1:0] irq_clr;
  logic [`LKE_NUM_LINES-1:0] irq_act;
  logic ctrl_wr;
  logic ctrl_rd;
  logic io_data_hit;
  logic io_cmd_hit;
  logic a20_match;
  logic out_full_fell;
  logic ext_irq;
  logic emul_cond;
  logic rd_data_port;
  logic wr_data_port;
  logic rd_cmd_port;
  logic wr_cmd_port;
  logic legacy_on;
  logic [`LKE_NUM_LINES-1:0] line_sel;
  logic [`LKE_NUM_LINES-1:0] line_out;
  logic [31:0] ctrl_image;

  // Byte offset decode used by both read and write paths
  function automatic logic is_ctrl(input logic [11:0] addr);
    is_ctrl = (addr == `LKE_OFS_CTRL);
  endfunction : is_ctrl

  // Legacy port decode, live only while emulation is switched on
  function automatic logic is_port(input logic en, input logic [7:0] addr,
                                   input logic [7:0] port);
    is_port = en && (addr == port);
  endfunction : is_port

  // Register port decode
  assign ctrl_wr = mem_wr && is_ctrl(mem_addr);
  assign ctrl_rd = mem_rd && is_ctrl(mem_addr);

  // Legacy ports decode only while emulation is on
  assign io_data_hit = is_port(st_r.ctrl.emul_enable, io_addr,
                               `LKE_IO_DATA);
  assign io_cmd_hit = is_port(st_r.ctrl.emul_enable, io_addr,
                              `LKE_IO_CMD);
  assign io_hit = (io_rd || io_wr) && (io_data_hit || io_cmd_hit);

  // One qualifier per legacy cycle kind
  assign rd_data_port = io_rd && io_data_hit;
  assign wr_data_port = io_wr && io_data_hit;
  assign rd_cmd_port = io_rd && io_cmd_hit;
  assign wr_cmd_port = io_wr && io_cmd_hit;

  // A gate A20 data byte that matches the held state needs no software
  assign a20_match = st_r.ctrl.a20_sequence
                     && (io_wdata[`LKE_A20_DATA_BIT]
                         == st_r.ctrl.a20_state);

  // Output-full falling edge, seen against last cycle's value
  assign out_full_fell = st_r.out_full_d && !out_full;

  // External lines request emulation service regardless of emul_enable
  assign ext_irq = st_r.ctrl.ext_irq_enable && (|irq_act);
  assign emul_cond = st_r.emul_evt || ext_irq;

  // Write-one-to-clear requests for the two edge latches
  assign irq_clr[`LKE_LINE_KBD] = ctrl_wr && mem_wdata[`LKE_BIT_KBDA];
  assign irq_clr[`LKE_LINE_AUX] = ctrl_wr && mem_wdata[`LKE_BIT_AUXA];
  assign irq_pins[`LKE_LINE_KBD] = kbd_irq_pin;
  assign irq_pins[`LKE_LINE_AUX] = aux_irq_pin;

  // One latch per keyboard controller interrupt line
  genvar gi;
  generate
    for (gi = 0; gi < `LKE_NUM_LINES; gi++) begin : g_line
      lke_edge_latch u_latch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .irq_pin(irq_pins[gi]),
        .clr(irq_clr[gi]),
        .active(irq_act[gi])
      );
    end
  endgenerate

  // Read-back image of the control register, reserved bits zero
  always_comb begin
    ctrl_image = `LKE_CTRL_RST;
    ctrl_image[`LKE_BIT_A20_STATE] = st_r.ctrl.a20_state;
    ctrl_image[`LKE_BIT_AUXA] = irq_act[`LKE_LINE_AUX];
    ctrl_image[`LKE_BIT_KBDA] = irq_act[`LKE_LINE_KBD];
    ctrl_image[`LKE_BIT_SEQ] = st_r.ctrl.a20_sequence;
    ctrl_image[`LKE_BIT_EXT] = st_r.ctrl.ext_irq_enable;
    ctrl_image[`LKE_BIT_LEG] = st_r.ctrl.legacy_irq_enable;
    ctrl_image[`LKE_BIT_CP] = st_r.ctrl.char_pending;
    ctrl_image[`LKE_BIT_EI] = emul_cond;
    ctrl_image[`LKE_BIT_EE] = st_r.ctrl.emul_enable;
  end

  // Next-state logic for control fields, events, read data and strobes
  always_comb begin
    st_nxt = st_r;
    st_nxt.strb = '0;
    st_nxt.out_full_d = out_full;
    // Software write updates every writable field at once
    if (ctrl_wr) begin
      st_nxt.ctrl.a20_state = mem_wdata[`LKE_BIT_A20_STATE];
      st_nxt.ctrl.a20_sequence = mem_wdata[`LKE_BIT_SEQ];
      st_nxt.ctrl.ext_irq_enable = mem_wdata[`LKE_BIT_EXT];
      st_nxt.ctrl.legacy_irq_enable = mem_wdata[`LKE_BIT_LEG];
      st_nxt.ctrl.char_pending = mem_wdata[`LKE_BIT_CP];
      st_nxt.ctrl.emul_enable = mem_wdata[`LKE_BIT_EE];
      st_nxt.emul_evt = 1'b0; // Any control write acknowledges the event
    end
    // Port 60h read returns the output byte and clears output-full
    if (rd_data_port) begin
      st_nxt.io_rdata = out_data;
      st_nxt.strb.clr_out_full = 1'b1;
    end
    // Port 64h read returns the status with no side effect
    if (rd_cmd_port) begin
      st_nxt.io_rdata = status_data;
    end
    // Port 60h write captures data; a matching A20 byte is handled silently
    if (wr_data_port) begin
      st_nxt.in_data = io_wdata;
      st_nxt.strb.load_in_data = 1'b1;
      st_nxt.strb.set_in_full = 1'b1;
      st_nxt.strb.clr_cmd_data = 1'b1;
      if (!a20_match) begin
        st_nxt.emul_evt = 1'b1;
      end
    end
    // Port 64h write tracks the gate A20 sequence and calls software
    if (wr_cmd_port) begin
      st_nxt.in_data = io_wdata;
      st_nxt.strb.load_in_data = 1'b1;
      st_nxt.strb.clr_in_full = 1'b1;
      st_nxt.strb.set_cmd_data = 1'b1;
      st_nxt.ctrl.a20_sequence = (io_wdata == `LKE_CMD_A20);
      st_nxt.emul_evt = 1'b1;
    end
    // Character pending fires when output-full drops
    if (st_r.ctrl.char_pending && st_r.ctrl.emul_enable
        && out_full_fell) begin
      st_nxt.emul_evt = 1'b1;
    end
    // Register read data from the live image
    if (ctrl_rd) begin
      st_nxt.mem_rdata = ctrl_image;
    end else if (mem_rd) begin
      st_nxt.mem_rdata = `LKE_CTRL_RST;
    end
  end

  // State register, cleared on reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Emulation drives a legacy line while both enables and output-full stand
  assign legacy_on = st_r.ctrl.emul_enable && st_r.ctrl.legacy_irq_enable
                     && out_full;

  // Aux-output-full routes the character to the mouse or keyboard line
  assign line_sel[`LKE_LINE_KBD] = !aux_out_full;
  assign line_sel[`LKE_LINE_AUX] = aux_out_full;

  // Each line is raised by emulation or by its own latched edge
  generate
    for (gi = 0; gi < `LKE_NUM_LINES; gi++) begin : g_out
      assign line_out[gi] = (legacy_on && line_sel[gi])
                            || irq_act[gi];
    end
  endgenerate
  assign irq1_out = line_out[`LKE_LINE_KBD];
  assign irq12_out = line_out[`LKE_LINE_AUX];
  assign emul_irq = emul_cond;

  // Registered data outputs
  assign mem_rdata = st_r.mem_rdata;
  assign io_rdata = st_r.io_rdata;
  assign in_data = st_r.in_data;
  assign status_strb = st_r.strb;

endmodule : lke_ctrl

// *** verification/lke_ctrl_asserts.sv ***
// Port-level checker of the emulation control block
`timescale 1ns/1ps
module lke_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mem_rd,
  input wire logic [11:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] in_data,
  input wire logic [7:0] out_data,
  input wire lke_pkg::lke_strb_t status_strb,
  input wire logic kbd_irq_pin,
  input wire logic aux_irq_pin,
  input wire logic irq1_out,
  input wire logic irq12_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Port decode and the side effects of each legacy cycle
  property p_hit;
    io_hit |-> (io_addr == 8'h60 || io_addr == 8'h64);
  endproperty
  a_hit: assert property (p_hit) else $error("decode of other port");
  property p_rd60;
    io_rd && io_hit && io_addr == 8'h60 |=>
      io_rdata == $past(out_data) && status_strb.clr_out_full;
  endproperty
  a_rd60: assert property (p_rd60) else $error("port 60h read");
  property p_wr60;
    io_wr && io_hit && io_addr == 8'h60 |=> in_data == $past(io_wdata) &&
      status_strb.set_in_full && status_strb.clr_cmd_data;
  endproperty
  a_wr60: assert property (p_wr60) else $error("port 60h write");
  property p_wr64;
    io_wr && io_hit && io_addr == 8'h64 |=>
      status_strb.set_cmd_data && status_strb.clr_in_full;
  endproperty
  a_wr64: assert property (p_wr64) else $error("port 64h write");
  property p_quiet; !(io_hit && (io_wr || io_rd)) |=> status_strb == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray strobe");
  // Register read-back shape
  property p_rsvd; mem_rd |=> mem_rdata[31:9] == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_unmap; mem_rd && mem_addr != 12'h100 |=> mem_rdata == '0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Pin edges reach the interrupt lines within the sync delay
  property p_kbd; $rose(kbd_irq_pin) |-> ##[2:4] irq1_out; endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard edge lost");
  property p_aux; $rose(aux_irq_pin) |-> ##[2:4] irq12_out; endproperty
  a_aux: assert property (p_aux) else $error("aux edge lost");
  c_rd60: cover property (io_rd && io_hit && io_addr == 8'h60);
  c_wr64: cover property (io_wr && io_hit && io_addr == 8'h64);
  c_kbd: cover property ($rose(kbd_irq_pin));
endmodule : lke_ctrl_asserts

bind lke_ctrl lke_ctrl_asserts u_lke_ctrl_asserts (.clk_sys, .rst_b, .mem_rd,
  .mem_addr, .mem_rdata, .io_wr, .io_rd, .io_addr, .io_wdata, .io_hit,
  .io_rdata, .in_data, .out_data, .status_strb, .kbd_irq_pin, .aux_irq_pin,
  .irq1_out, .irq12_out);

// *** verification/lke_status_model.sv ***
// Model of the status and output registers beside the control block
`timescale 1ns/1ps
module lke_status_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic load,
  input wire logic load_aux,
  input wire logic [7:0] load_byte,
  input wire lke_pkg::lke_strb_t status_strb,
  output logic out_full,
  output logic aux_out_full,
  output logic [7:0] out_data,
  output logic [7:0] status_data
);
  logic in_full_r;
  logic cmd_data_r;
  // Software loads a byte; legacy port cycles move the flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {out_full, aux_out_full, out_data, in_full_r, cmd_data_r} <= '0;
    end else begin
      if (load) begin
        {out_full, aux_out_full, out_data} <= {1'b1, load_aux, load_byte};
      end else if (status_strb.clr_out_full) begin
        out_full <= 1'b0;
      end
      if (status_strb.set_in_full || status_strb.clr_in_full) begin
        in_full_r <= status_strb.set_in_full;
      end
      if (status_strb.set_cmd_data || status_strb.clr_cmd_data) begin
        cmd_data_r <= status_strb.set_cmd_data;
      end
    end
  end
  assign status_data = {2'h0, aux_out_full, 1'b0, cmd_data_r, 1'b0, in_full_r,
    out_full};
endmodule : lke_status_model

// *** verification/legacy_kbd_emulation_control_bench.sv ***
// Self-checking bench of the emulation control block
`timescale 1ns/1ps
module legacy_kbd_emulation_control_bench;
  logic clk_sys, rst_b, mem_wr, mem_rd, io_wr, io_rd, io_hit, load, load_aux;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic [7:0] io_addr, io_wdata, io_rdata, in_data, out_data, status_data;
  logic [7:0] load_byte;
  logic out_full, aux_out_full, kbd_irq_pin, aux_irq_pin;
  logic irq1_out, irq12_out, emul_irq;
  lke_pkg::lke_strb_t status_strb;
  int n_mismatch, n_tests;
  lke_ctrl u_lke_ctrl (.clk_sys, .rst_b, .mem_wr, .mem_rd, .mem_addr,
    .mem_wdata, .mem_rdata, .io_wr, .io_rd, .io_addr, .io_wdata, .io_hit,
    .io_rdata, .in_data, .out_full, .aux_out_full, .out_data, .status_data,
    .status_strb, .kbd_irq_pin, .aux_irq_pin, .irq1_out, .irq12_out,
    .emul_irq);
  lke_status_model u_lke_status_model (.clk_sys, .rst_b, .load, .load_aux,
    .load_byte, .status_strb, .out_full, .aux_out_full, .out_data,
    .status_data);
  // Clock source
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task mw(input logic [11:0] a, input logic [31:0] v);
    {mem_wr, mem_addr, mem_wdata} = {1'b1, a, v};
    @(posedge clk_sys) #1 mem_wr = 1'b0;
    @(posedge clk_sys) #1; // Idle edge between transfers
  endtask : mw
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    {mem_rd, mem_addr} = {1'b1, a};
    @(posedge clk_sys) #1 mem_rd = 1'b0;
    chk(mem_rdata, exp);
    @(posedge clk_sys) #1; // Idle edge between transfers
  endtask : rdc
  task io(input logic wr, input logic [7:0] a, input logic [7:0] v);
    {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, v};
    @(posedge clk_sys) #1 {io_wr, io_rd} = 2'h0;
    @(posedge clk_sys) #1; // Idle edge between transfers
  endtask : io
  task ld(input logic aux, input logic [7:0] v);
    {load, load_aux, load_byte} = {1'b1, aux, v};
    @(posedge clk_sys) #1 load = 1'b0;
    @(posedge clk_sys) #1; // Idle edge between loads
  endtask : ld
  task t_basic;
    rdc(12'h100, 32'h0);
    mw(12'h104, 32'hFFFF_FFFF);
    rdc(12'h104, 32'h0);
    io(1'b1, 8'h64, 8'hD1);
    rdc(12'h100, 32'h0);
  endtask : t_basic
  task t_a20;
    mw(12'h100, 32'h1);
    io(1'b1, 8'h64, 8'hD1);
    rdc(12'h100, 32'h23);
    io(1'b1, 8'h64, 8'h00);
    rdc(12'h100, 32'h3);
    mw(12'h100, 32'h3);
    rdc(12'h100, 32'h1);
    mw(12'h100, 32'h101);
    io(1'b1, 8'h64, 8'hD1);
    mw(12'h100, 32'h121);
    io(1'b1, 8'h60, 8'h02);
    chk(emul_irq, 1'b0);
    io(1'b1, 8'h60, 8'h00);
    chk(emul_irq, 1'b1);
    chk(in_data, 8'h00);
  endtask : t_a20
  task t_legacy;
    mw(12'h100, 32'h9);
    ld(1'b0, 8'h5A);
    chk({irq1_out, irq12_out}, 2'h2);
    ld(1'b1, 8'hA5);
    chk({irq1_out, irq12_out}, 2'h1);
    io(1'b0, 8'h64, 8'h00);
    chk(io_rdata, 8'h23);
    io(1'b0, 8'h60, 8'h00);
    chk(io_rdata, 8'hA5);
    @(posedge clk_sys) #1 chk(irq12_out, 1'b0);
  endtask : t_legacy
  task t_pending;
    mw(12'h100, 32'h5);
    ld(1'b0, 8'h11);
    chk(emul_irq, 1'b0);
    io(1'b0, 8'h60, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk(emul_irq, 1'b1);
  endtask : t_pending
  task t_edge(input logic aux);
    int i;
    mw(12'h100, 32'h10);
    {aux_irq_pin, kbd_irq_pin} = {aux, !aux};
    for (i = 0; i < 8 && !(aux ? irq12_out : irq1_out); i++) begin
      @(posedge clk_sys) #1;
    end
    if (i == 8) begin
      n_mismatch++;
      $display("wrong value at %0t: interrupt line never rose", $time);
    end
    rdc(12'h100, aux ? 32'h92 : 32'h52);
    mw(12'h100, aux ? 32'h90 : 32'h50);
    rdc(12'h100, 32'h10);
    {aux_irq_pin, kbd_irq_pin} = 2'h0;
  endtask : t_edge
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Reset, then the scenarios in turn
  initial begin
    {rst_b, mem_wr, mem_rd, io_wr, io_rd, load, load_aux} = '0;
    {mem_addr, mem_wdata, io_addr, io_wdata, load_byte} = '0;
    {kbd_irq_pin, aux_irq_pin, n_mismatch, n_tests} = '0;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_basic();
    t_a20();
    t_legacy();
    t_pending();
    t_edge(1'b0);
    t_edge(1'b1);
    tally_and_finish();
  end
endmodule : legacy_kbd_emulation_control_bench
